// file: design/sfs_consts.vh
// Command codes, status bit positions and timing constants of the flash command sequencer.
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

// Opcodes that the decoder recognises.
`define SFS_OP_NOP 8'h00
`define SFS_OP_PAGE_WRITE 8'h02
`define SFS_OP_READ 8'h03
`define SFS_OP_WRITE_FORBID 8'h04
`define SFS_OP_STATUS_READ 8'h05
`define SFS_OP_WRITE_PERMIT 8'h06
`define SFS_OP_FAST_READ 8'h0B
`define SFS_OP_CONFIG_READ 8'h15
`define SFS_OP_SEC_READ 8'h2B
`define SFS_OP_SEC_WRITE 8'h2F
`define SFS_OP_RESUME_A 8'h7A
`define SFS_OP_RESUME_B 8'h30
`define SFS_OP_SUSPEND_A 8'hB0
`define SFS_OP_SUSPEND_B 8'h75
`define SFS_OP_QUAD_PAGE_WRITE 8'h38
`define SFS_OP_DUAL_READ 8'h3B
`define SFS_OP_PARAM_READ 8'h5A
`define SFS_OP_RESET_ARM 8'h66
`define SFS_OP_QUAD_READ 8'h6B
`define SFS_OP_MAKER_READ 8'h90
`define SFS_OP_IDENT_READ 8'h9F
`define SFS_OP_RESET_FIRE 8'h99
`define SFS_OP_SIGNATURE 8'hAB
`define SFS_OP_OTP_ENTER 8'hB1
`define SFS_OP_OTP_EXIT 8'hC1
`define SFS_OP_X2_READ 8'hBB
`define SFS_OP_BURST_LEN 8'hC0
`define SFS_OP_X4_READ 8'hEB
`define SFS_OP_SECTOR_ERASE 8'h20
`define SFS_OP_BLOCK32_ERASE 8'h52
`define SFS_OP_BLOCK64_ERASE 8'hD8

// Security register bit positions.
`define SFS_SEC_LOCKDOWN 1
`define SFS_SEC_PSUSP 2
`define SFS_SEC_ESUSP 3

// Timing constants, in cycles of the 20 MHz clock (50 ns period).
// The cycle counts are sized to the 19-bit timers so that no port or register has to trim them.
`define SFS_CLK_NS 50
`define SFS_SUSP_LAT_NS 20000
// Suspend latency: 20 us is 400 cycles.
`define SFS_SUSP_LAT_CYC 19'h0_0190
`define SFS_RST_RECOV_MS 12
// Long reset recovery: 12 ms is 240000 cycles.
`define SFS_RST_RECOV_CYC 19'h3_a980
// Short reset recovery, used when no program or erase was under way.
`define SFS_RST_RECOV_SHORT_CYC 19'h0_0258

`endif

// file: design/sfs_countdown.v
// Loadable down-counter that reports when it has run out.
`default_nettype none
module sfs_countdown (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rst_n,
  // Load strobe and value.
  input wire i_load,
  input wire [18:0] i_value,
  // Counter state.
  output wire o_busy,
  output wire o_done
);
  reg [18:0] cnt_r;
  reg done_r;

  // A load restarts the count; the done pulse comes when it reaches zero.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 19'h0_0000;
      done_r <= 1'b0;
    end else if (i_load) begin
      cnt_r <= i_value;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == 19'h0_0001);
      if (cnt_r != 19'h0_0000) begin
        cnt_r <= cnt_r - 19'h0_0001;
      end
    end
  end
  assign o_busy = (cnt_r != 19'h0_0000);
  assign o_done = done_r;
endmodule
`default_nettype wire

// file: design/sfs_sequencer.v
// Command sequencer of a serial flash: suspend, resume, lock-down and software reset.
`include "sfs_consts.vh"
`default_nettype none
module sfs_sequencer #(
  parameter [18:0] RST_RECOV_CYC = `SFS_RST_RECOV_CYC
) (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rst_n,
  // Serial link pins.
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdi,
  // Array engine: operation completion and mode.
  input wire i_op_done,
  input wire i_perf_mode,
  // Status outputs.
  output wire [7:0] o_status,
  output wire [7:0] o_security,
  output wire o_busy_recovering,
  output wire o_op_active,
  output wire [1:0] o_op_kind,
  output wire o_otp_locked
);
  // Operation kinds.
  localparam [1:0] OP_PROG = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;
  // One-hot array states.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_BUSY = 5'h02;
  localparam [4:0] ST_SLAT = 5'h04;
  localparam [4:0] ST_SUSP = 5'h08;
  localparam [4:0] ST_NPROG = 5'h10;

  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  reg sclk_d_r;
  reg [7:0] shift_r;
  reg [2:0] bitcnt_r;
  reg [7:0] opcode_r;
  reg have_op_r;
  reg cs_d_r;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [1:0] kind_r;
  reg wel_r;
  reg wip_r;
  reg psusp_r;
  reg esusp_r;
  reg lockdown_r;
  reg arm_r;
  reg [7:0] status_r;
  reg [7:0] security_r;
  reg recov_load;
  reg [18:0] recov_val;
  reg lat_load;
  wire lat_busy;
  wire lat_done;
  wire recov_busy;

  // Pins cross into the clock domain before any decode looks at them.
  // Select idles high, so its synchroniser leaves reset deselected and no false select edge follows.
  sfs_sync2 u_sync_cs (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_cs_n),
    .i_rst_val(1'b1),
    .o_sync(cs_n_s)
  );
  // The serial clock parks low between frames, so a low reset value avoids a phantom rising edge.
  sfs_sync2 u_sync_sck (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_sclk),
    .i_rst_val(1'b0),
    .o_sync(sclk_s)
  );
  // Data takes the same two-flop delay as the serial clock, so a bit is still settled at its clock edge.
  sfs_sync2 u_sync_sdi (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_sdi),
    .i_rst_val(1'b0),
    .o_sync(sdi_s)
  );

  // Suspend latency and reset recovery timers.
  // Only the busy state takes a suspend, so the latency timer is never reloaded while it runs.
  sfs_countdown u_lat (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_load(lat_load),
    .i_value(`SFS_SUSP_LAT_CYC),
    .o_busy(lat_busy),
    .o_done(lat_done)
  );
  sfs_countdown u_recov (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_load(recov_load),
    .i_value(recov_val),
    .o_busy(recov_busy),
    .o_done()
  );

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sel_active = ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_d_r;
  // A command ends when select rises; boundary holds when no partial byte is left.
  wire cmd_end = cs_rise & have_op_r;
  wire on_boundary = (bitcnt_r == 3'h0);
  wire [7:0] op = opcode_r;

  // Command class decode.
  wire is_read_set = (op == `SFS_OP_READ) | (op == `SFS_OP_FAST_READ) | (op == `SFS_OP_DUAL_READ) |
                     (op == `SFS_OP_QUAD_READ) | (op == `SFS_OP_X2_READ) | (op == `SFS_OP_X4_READ) |
                     (op == `SFS_OP_PARAM_READ) | (op == `SFS_OP_IDENT_READ) | (op == `SFS_OP_MAKER_READ) |
                     (op == `SFS_OP_BURST_LEN) | (op == `SFS_OP_OTP_ENTER) | (op == `SFS_OP_OTP_EXIT);
  wire is_resume = (op == `SFS_OP_RESUME_A) | (op == `SFS_OP_RESUME_B);
  wire is_suspend = (op == `SFS_OP_SUSPEND_A) | (op == `SFS_OP_SUSPEND_B);
  wire is_pwrite = (op == `SFS_OP_PAGE_WRITE) | (op == `SFS_OP_QUAD_PAGE_WRITE);
  wire is_erase = (op == `SFS_OP_SECTOR_ERASE) | (op == `SFS_OP_BLOCK32_ERASE) | (op == `SFS_OP_BLOCK64_ERASE);
  wire is_anytime = (op == `SFS_OP_WRITE_FORBID) | (op == `SFS_OP_STATUS_READ) | (op == `SFS_OP_CONFIG_READ) |
                    (op == `SFS_OP_SEC_READ) | (op == `SFS_OP_SIGNATURE) | (op == `SFS_OP_RESET_ARM) |
                    (op == `SFS_OP_RESET_FIRE) | (op == `SFS_OP_NOP);
  // State bits are read directly, which is safe because the state codes are one-hot.
  wire in_susp = state_r[3];
  wire in_slat = state_r[2];
  wire erase_susp = in_susp & (kind_r == OP_ERASE);

  // Acceptance while suspended: latency-free set always, others only after latency.
  // The nested program state takes every opcode here, because each action below except the reset fire gates itself on state;
  // this keeps the refusal rules in one place. During recovery every command is dropped, a reset arm too.
  wire allowed_susp = is_anytime | (in_susp & (is_read_set | is_resume)) |
                      (erase_susp & (is_pwrite | (op == `SFS_OP_WRITE_PERMIT)));
  wire suspended_like = in_susp | in_slat | state_r[4];
  wire accept = cmd_end & ~recov_busy & (~suspended_like | allowed_susp | state_r[4]);

  wire do_write_permit_cmd = accept & (op == `SFS_OP_WRITE_PERMIT) & ~state_r[4];
  wire do_write_forbid_cmd = accept & (op == `SFS_OP_WRITE_FORBID) & ~state_r[4];
  wire do_secw = accept & (op == `SFS_OP_SEC_WRITE) & state_r[0] & wel_r & on_boundary;
  wire do_prog = accept & is_pwrite & wel_r & (state_r[0] | erase_susp);
  wire do_erase = accept & is_erase & wel_r & state_r[0];
  wire do_susp = accept & is_suspend & state_r[1];
  wire do_resume = accept & is_resume & in_susp & ~i_perf_mode;
  wire do_fire = accept & (op == `SFS_OP_RESET_FIRE) & arm_r;

  // Sample the link clock and select, shift in bits on rising serial clock.
  // Bits past the first byte still advance the bit counter, which is all the boundary check needs.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      shift_r <= 8'h00;
      bitcnt_r <= 3'h0;
      opcode_r <= 8'h00;
      have_op_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
      if (!sel_active) begin
        bitcnt_r <= 3'h0;
        if (cs_rise) begin
          have_op_r <= 1'b0;
        end
      end else if (sclk_rise) begin
        shift_r <= {shift_r[6:0], sdi_s};
        bitcnt_r <= bitcnt_r + 3'h1;
        if (bitcnt_r == 3'h7 && !have_op_r) begin
          opcode_r <= {shift_r[6:0], sdi_s};
          have_op_r <= 1'b1;
        end
      end
    end
  end

  // Array state transitions.
  // A completion that arrives during the suspend latency is not tracked; the array engine is expected
  // to hold off its done pulse once a suspend has been taken.
  always @* begin
    state_nxt = state_r;
    lat_load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (do_prog || do_erase) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (do_susp) begin
          state_nxt = ST_SLAT;
          lat_load = 1'b1;
        end else if (i_op_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SLAT: begin
        if (lat_done) begin
          state_nxt = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (do_resume) begin
          state_nxt = ST_BUSY;
        end else if (do_prog) begin
          state_nxt = ST_NPROG;
        end
      end
      ST_NPROG: begin
        if (i_op_done) begin
          state_nxt = ST_SUSP;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (do_fire) begin
      state_nxt = ST_IDLE;
    end
  end

  // Recovery time depends on what the reset interrupted.
  always @* begin
    recov_load = do_fire;
    recov_val = `SFS_RST_RECOV_SHORT_CYC;
    if ((state_r[1] || state_r[2] || state_r[3]) && kind_r == OP_ERASE) begin
      recov_val = RST_RECOV_CYC;
    end else if (state_r[1] || state_r[2] || state_r[3] || state_r[4]) begin
      // A suspended program is still an unfinished program, so it takes the long recovery too.
      recov_val = RST_RECOV_CYC;
    end
  end

  // Status, suspend and lock-down bookkeeping.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      kind_r <= 2'h0;
      wel_r <= 1'b0;
      wip_r <= 1'b0;
      psusp_r <= 1'b0;
      esusp_r <= 1'b0;
      lockdown_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (do_fire) begin
        // Volatile bits return to power-on defaults; lock-down is non-volatile.
        kind_r <= 2'h0;
        wel_r <= 1'b0;
        wip_r <= 1'b0;
        psusp_r <= 1'b0;
        esusp_r <= 1'b0;
        arm_r <= 1'b0;
      end else begin
        // Any accepted command other than arm cancels a pending arm.
        if (accept) begin
          arm_r <= (op == `SFS_OP_RESET_ARM);
        end
        if (do_write_permit_cmd) begin
          wel_r <= 1'b1;
        end else if (do_write_forbid_cmd) begin
          wel_r <= 1'b0;
        end
        if (do_secw) begin
          wel_r <= 1'b0;
          lockdown_r <= 1'b1;
        end
        if (state_r[0] && (do_prog || do_erase)) begin
          kind_r <= do_prog ? OP_PROG : OP_ERASE;
          wip_r <= 1'b1;
        end
        if (do_prog && erase_susp) begin
          wip_r <= 1'b1;
        end
        // A completion that meets a suspend in the same cycle is left to the suspend path.
        if ((state_r[1] || state_r[4]) && i_op_done && !do_susp) begin
          wel_r <= 1'b0;
          wip_r <= 1'b0;
        end
        if (state_r[2] && lat_done) begin
          wel_r <= 1'b0;
          psusp_r <= (kind_r == OP_PROG);
          esusp_r <= (kind_r == OP_ERASE);
        end
        if (do_resume) begin
          wel_r <= 1'b1;
          wip_r <= 1'b1;
          psusp_r <= 1'b0;
          esusp_r <= 1'b0;
        end
      end
    end
  end

  // Registered status images for reading.
  // Reading goes through one more flop, so a host sees a change one cycle after the state moves.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_r <= 8'h00;
      security_r <= 8'h00;
    end else begin
      status_r <= {6'h00, wel_r, wip_r};
      security_r <= {4'h0, esusp_r, psusp_r, lockdown_r, 1'b0};
    end
  end

  assign o_status = status_r;
  assign o_security = security_r;
  assign o_busy_recovering = recov_busy;
  assign o_op_active = wip_r;
  assign o_op_kind = kind_r;
  assign o_otp_locked = lockdown_r;
  // The latency timer's busy output is not needed: its done pulse alone moves the state.
  wire unused_ok = lat_busy;
endmodule
`default_nettype wire

// file: design/sfs_sync2.v
// Two-flop synchroniser for an input from outside the clock domain.
`default_nettype none
module sfs_sync2 (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rst_n,
  // Asynchronous input, reset value and synchronised output.
  input wire i_async,
  input wire i_rst_val,
  output wire o_sync
);
  reg meta_r;
  reg sync_r;

  // Only the second flop is read outside this module.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_async ^ i_rst_val;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r ^ i_rst_val;
endmodule
`default_nettype wire

// file: tb/sfs_host_model.sv
// Behavioural host controller that frames opcodes onto the serial link.
`default_nettype none
module sfs_host_model (
  // Clock.
  input wire logic i_mclk,
  // Serial link toward the flash.
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi
);
  timeunit 1ns / 1ps;
  int hp = 4;
  // The link idles deselected with its clock parked low.
  // This host never raises the protect pin to high voltage, so it has no high-voltage select setup to wait
  // for and no program to hold that voltage through; a host that does must poll write_in_progress first.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // Sends nb bits, opcode MSB first; bits past eight repeat the opcode, inverted on every other pass.
  task automatic frame(input logic [7:0] op, input int nb);
    logic [7:0] sh;
    sh = op;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_sdi <= sh[7];
      sh = {sh[6:0], ~sh[7]};
      repeat (hp) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (hp) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    repeat (hp) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// file: tb/sfs_sequencer_properties.sv
// Assertion checker of the flash command sequencer ports, with its bind.
`default_nettype none
module sfs_seq_chk #(
  parameter [18:0] RST_RECOV_CYC = 19'h3_a980
) (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rst_n,
  // Inputs of the sequencer.
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdi,
  input wire i_op_done,
  input wire i_perf_mode,
  // Outputs of the sequencer.
  input wire [7:0] o_status,
  input wire [7:0] o_security,
  input wire o_busy_recovering,
  input wire o_op_active,
  input wire [1:0] o_op_kind,
  input wire o_otp_locked
);
  timeunit 1ns / 1ps;
  // The longest recovery is the larger of the long and short counts, plus slack for the status flop.
  localparam int LIM = ((RST_RECOV_CYC > 600) ? RST_RECOV_CYC : 600) + 4;
  logic [19:0] rec_cnt_r;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Counts the cycles of one recovery period, since a repetition that long would choke the tools.
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec_cnt_r <= 20'h0_0000;
    end else if (o_busy_recovering) begin
      rec_cnt_r <= rec_cnt_r + 20'h0_0001;
    end else begin
      rec_cnt_r <= 20'h0_0000;
    end
  end
  // Lock-down, suspend, completion and recovery relations.
  property p_lock_sticky; o_otp_locked |=> o_otp_locked; endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock flag dropped");
  property p_lock_bit; $rose(o_otp_locked) |-> ##[0:2] o_security[1]; endproperty
  a_lock_bit: assert property (p_lock_bit) else $error("lock bit not shown");
  property p_susp_excl; !(o_security[2] && o_security[3]); endproperty
  a_susp_excl: assert property (p_susp_excl) else $error("both suspend flags set");
  property p_susp_latch; $rose(o_security[2] || o_security[3]) |-> ##[0:2] !o_status[1]; endproperty
  a_susp_latch: assert property (p_susp_latch) else $error("permit latch kept on suspend");
  property p_busy_img; $rose(o_op_active) |-> ##[0:2] o_status[0]; endproperty
  a_busy_img: assert property (p_busy_img) else $error("busy bit not shown");
  property p_recov_status; $rose(o_busy_recovering) |-> ##[0:2] (o_status == 8'h00); endproperty
  a_recov_status: assert property (p_recov_status) else $error("status not cleared by reset");
  property p_recov_idle;
    $rose(o_busy_recovering) |-> ##[0:2] (o_op_kind == 2'd0 && !o_op_active && o_security[3:2] == 2'b00);
  endproperty
  a_recov_idle: assert property (p_recov_idle) else $error("operation not aborted by reset");
  property p_recov_bound; rec_cnt_r <= LIM; endproperty
  a_recov_bound: assert property (p_recov_bound) else $error("recovery too long");
  property p_recov_quiet; o_busy_recovering |=> !$rose(o_op_active); endproperty
  a_recov_quiet: assert property (p_recov_quiet) else $error("operation started in recovery");
  property p_done; i_op_done && o_op_active |-> ##[1:3] !o_op_active; endproperty
  a_done: assert property (p_done) else $error("busy kept after completion");
  c_psusp: cover property ($rose(o_security[2]));
  c_esusp: cover property ($rose(o_security[3]));
  c_recov: cover property ($rose(o_busy_recovering));
endmodule
bind sfs_sequencer sfs_seq_chk #(.RST_RECOV_CYC(RST_RECOV_CYC)) u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_sdi(i_sdi),
  .i_op_done(i_op_done), .i_perf_mode(i_perf_mode), .o_status(o_status), .o_security(o_security),
  .o_busy_recovering(o_busy_recovering), .o_op_active(o_op_active), .o_op_kind(o_op_kind),
  .o_otp_locked(o_otp_locked));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the flash command sequencer.
`include "sfs_consts.vh"
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  // Long recovery is kept above the short one, as after a program or erase the wait must be longer.
  localparam int RCV = 800;
  localparam int SHORT = `SFS_RST_RECOV_SHORT_CYC;
  // Resume-to-suspend gap that the host keeps, in clock cycles; a plain default.
  localparam int GAP = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic op_done = 1'b0;
  logic perf = 1'b0;
  logic [15:0] lfsr = 16'h953d;
  wire cs_n, sclk, sdi, recov, active, lock;
  wire [7:0] status, sec;
  wire [1:0] kind;
  int error_cnt = 0;
  int total_checks = 0;
  int nb;
  int n;
  sfs_host_model host (.i_mclk(mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
  sfs_sequencer #(.RST_RECOV_CYC(19'(RCV))) uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_sdi(sdi), .i_op_done(op_done), .i_perf_mode(perf), .o_status(status),
    .o_security(sec), .o_busy_recovering(recov), .o_op_active(active), .o_op_kind(kind), .o_otp_locked(lock));
  // Free-running system clock.
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Random source and expected images.
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] sec_img(input logic lk, input logic ps, input logic es);
    return {4'h0, es, ps, lk, 1'b0};
  endfunction
  function automatic bit esusp_ok(input logic [7:0] op);
    return op inside {8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h5a, 8'h9f, 8'h90, 8'hc0, 8'hb1, 8'hc1,
      8'h06, 8'h7a, 8'h30, 8'h02, 8'h38, 8'h04, 8'h05, 8'h15, 8'h2b, 8'hab, 8'h66, 8'h99, 8'h00};
  endfunction
  // Comparison, command and pacing helpers.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame(op, 8);
    @(negedge mclk);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic pulse_done;
    @(posedge mclk);
    op_done <= 1'b1;
    @(posedge mclk);
    op_done <= 1'b0;
    settle(4);
  endtask
  // Counts the cycles until recovery ends, bounded so that a stuck recovery counts as a mismatch.
  task automatic wait_recovery;
    for (n = 0; recov && n < 2000; n++) @(negedge mclk);
    if (n >= 2000) begin
      error_cnt++;
      $display("unexpected at %0t: recovery never ended", $time);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence: lock-down, both suspend types, then the two-step reset.
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    settle(3);
    check(status, 8'h00);
    check({3'h0, lock, recov, active, kind}, 8'h00);
    $display("test reset done");
    cmd(8'h2f);
    check(sec, sec_img(0, 0, 0));
    cmd(8'h06);
    check(status, 8'h02);
    lfsr = lfsr_next(lfsr);
    nb = (lfsr[0] ? 9 : 1) + lfsr[3:1] % 7;
    host.frame(8'h2f, nb);
    @(negedge mclk);
    check(sec, sec_img(0, 0, 0));
    cmd(8'h06);
    cmd(8'h2f);
    check(sec, sec_img(1, 0, 0));
    $display("test lockdown done");
    cmd(8'h06);
    cmd(8'h02);
    check({5'h0, kind, active}, 8'h03);
    cmd(8'hb0);
    check(sec, sec_img(1, 0, 0));
    settle(`SFS_SUSP_LAT_CYC);
    check(sec, sec_img(1, 1, 0));
    check({7'h0, status[1]}, 8'h00);
    cmd(8'h06);
    check({7'h0, status[1]}, 8'h00);
    // A read taken in the suspend cancels the pending arm, so the fire after it must do nothing.
    cmd(8'h66);
    cmd(8'heb);
    cmd(8'h99);
    check({7'h0, recov}, 8'h00);
    @(posedge mclk);
    perf <= 1'b1;
    cmd(8'h7a);
    check(sec, sec_img(1, 1, 0));
    @(posedge mclk);
    perf <= 1'b0;
    cmd(8'h30);
    check(sec, sec_img(1, 0, 0));
    check({6'h0, status[1:0]}, 8'h03);
    pulse_done;
    check({7'h0, active}, 8'h00);
    $display("test program suspend done");
    cmd(8'h06);
    cmd(8'h20);
    check({5'h0, kind, active}, 8'h05);
    cmd(8'h75);
    settle(`SFS_SUSP_LAT_CYC);
    check(sec, sec_img(1, 0, 1));
    // Random opcodes outside the accepted set must leave the suspend untouched.
    for (n = 0; n < 4;) begin
      lfsr = lfsr_next(lfsr);
      if (!esusp_ok(lfsr[7:0])) begin
        cmd(lfsr[7:0]);
        check(sec, sec_img(1, 0, 1));
        n++;
      end
    end
    check({7'h0, status[1]}, 8'h00);
    cmd(8'h06);
    check({7'h0, status[1]}, 8'h01);
    cmd(8'h04);
    check({7'h0, status[1]}, 8'h00);
    cmd(8'h06);
    cmd(8'h38);
    check({6'h0, status[1:0]}, 8'h03);
    cmd(8'hb0);
    settle(`SFS_SUSP_LAT_CYC);
    check(sec, sec_img(1, 0, 1));
    check({6'h0, status[1:0]}, 8'h03);
    pulse_done;
    check({6'h0, status[1:0]}, 8'h00);
    cmd(8'h7a);
    check(sec, sec_img(1, 0, 0));
    check({6'h0, status[1:0]}, 8'h03);
    // The host keeps the resume-to-suspend gap before it suspends the erase once more.
    settle(GAP);
    cmd(8'h75);
    settle(`SFS_SUSP_LAT_CYC);
    check(sec, sec_img(1, 0, 1));
    cmd(8'h30);
    check(sec, sec_img(1, 0, 0));
    $display("test erase suspend done");
    cmd(8'h66);
    cmd(8'h00);
    cmd(8'h99);
    check({7'h0, recov}, 8'h00);
    cmd(8'h66);
    cmd(8'h05);
    cmd(8'h99);
    check({7'h0, recov}, 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    check({7'h0, recov}, 8'h01);
    check(status, 8'h00);
    check({7'h0, lock}, 8'h01);
    wait_recovery;
    check({7'h0, n > RCV - 30 && n <= RCV + 4}, 8'h01);
    check({5'h0, kind, active}, 8'h00);
    cmd(8'h06);
    check(status, 8'h02);
    // From standby the recovery is the short one, shorter than after an erase.
    cmd(8'h66);
    cmd(8'h99);
    check(status, 8'h00);
    wait_recovery;
    check({7'h0, n > SHORT - 30 && n <= SHORT + 4}, 8'h01);
    $display("test software reset done");
    test_done;
  end
endmodule
`default_nettype wire
